// File: design/flrb_builder.sv
// Purpose: builds record bytes 13..39 (peaks, temperatures, newest event page)
// Assumes: readings arrive tagged with sequencer step; peaks come from trackers
// Notes:   byte stream leaves through an 8-deep fifo with back-pressure
//          page fields are a snapshot taken at the close of the fault pass;
//          live copies keep tracking so no later reading reaches the record
// ****************************************************************
// ****************************************************************
module flrb_builder
    import flrb_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        clk_en_in,
    input  wire logic        fault_in,
    input  wire logic        adc_valid_in,
    input  wire logic [4:0]  adc_step_in,
    input  wire logic [15:0] adc_data_in,
    input  wire logic [15:0] peak_channel_input_current_in,
    input  wire logic [15:0] peak_input_voltage_in,
    input  wire logic [15:0] peak_external_temperature_in,
    input  wire logic [7:0]  vout_status_in,
    input  wire logic        log_present_in,
    input  wire logic        fault_record_read_in,
    input  wire logic        store_done_in,
    output logic             store_req_out,
    output logic [7:0]       block_len_out,
    output logic             byte_valid_out,
    input  wire logic        byte_ready_in,
    output logic [7:0]       byte_data_out,
    output logic             busy_out
);
    // two copies of every reading: lv_* follow the sequencer all the time,
    // the plain fields are the frozen page that the record reads out; one
    // copy alone would let readings taken after the pass closes overwrite the page
    typedef struct packed {
        flrb_state_t state;
        logic [7:0]  pos;
        logic [15:0] vout;
        logic [15:0] iout;
        logic [15:0] ichan;
        logic [15:0] vin;
        logic [15:0] iin;
        logic [15:0] text;
        logic [15:0] tint;
        logic [15:0] lv_vout;
        logic [15:0] lv_iout;
        logic [15:0] lv_ichan;
        logic [15:0] lv_vin;
        logic [15:0] lv_iin;
        logic [15:0] lv_text;
        logic [15:0] lv_tint;
        logic [15:0] pk_ichan;
        logic [15:0] pk_vin;
        logic [15:0] pk_text;
        logic [7:0]  vstat;
        logic        req;
        logic [7:0]  len;
    } flrb_regs_t;

    flrb_regs_t r_ff;
    flrb_regs_t nxt_r;
    logic       fifo_ready;
    logic       emit_valid;
    logic [7:0] emit_byte;

    // ****************************************************************
    // byte selector
    // ****************************************************************
    function automatic logic [7:0] flrb_pick(input logic [15:0] w, input logic hi);
        flrb_pick = hi ? w[15:8] : w[7:0];
    endfunction

    // maps a record position onto its captured field
    // odd positions carry the upper byte of every 16-bit field
    function automatic logic [7:0] flrb_byte(input flrb_regs_t s, input logic [7:0] p);
        logic hi;
        hi = !p[0];
        case (p)
            8'd13, 8'd14: flrb_byte = flrb_pick(s.pk_ichan, !hi);
            8'd15, 8'd16: flrb_byte = flrb_pick(s.pk_vin, !hi);
            8'd17, 8'd18: flrb_byte = flrb_pick(s.text, !hi);
            8'd21, 8'd22: flrb_byte = flrb_pick(s.tint, !hi);
            8'd23, 8'd24: flrb_byte = flrb_pick(s.pk_text, !hi);
            8'd27, 8'd28: flrb_byte = flrb_pick(s.vout, !hi);
            8'd31, 8'd32: flrb_byte = flrb_pick(s.iout, !hi);
            8'd33, 8'd34: flrb_byte = flrb_pick(s.ichan, !hi);
            8'd35, 8'd36: flrb_byte = flrb_pick(s.vin, !hi);
            8'd37, 8'd38: flrb_byte = flrb_pick(s.iin, !hi);
            8'd39:        flrb_byte = s.vstat;
            default:      flrb_byte = FLRB_RSVD_BYTE;
        endcase
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    // order inside: live capture, length, then the state machine; a fault in
    // idle outranks a read seen in the same cycle, and both are ignored while
    // busy since only one record job runs at a time
    always_comb begin
        nxt_r      = r_ff;
        emit_valid = 1'b0;
        emit_byte  = flrb_byte(r_ff, r_ff.pos);
        // live copies follow every conversion in every state, so a pass that
        // straddles a read or a store is never missing a step
        if (adc_valid_in) begin
            case (adc_step_in)
                FLRB_STEP_VOUT:  nxt_r.lv_vout  = adc_data_in;   // mantissa only
                FLRB_STEP_IOUT:  nxt_r.lv_iout  = adc_data_in;
                FLRB_STEP_ICHAN: nxt_r.lv_ichan = adc_data_in;
                FLRB_STEP_VIN:   nxt_r.lv_vin   = adc_data_in;
                FLRB_STEP_IIN:   nxt_r.lv_iin   = adc_data_in;
                FLRB_STEP_TEXT:  nxt_r.lv_text  = adc_data_in;
                FLRB_STEP_TINT:  nxt_r.lv_tint  = adc_data_in;
                default:         nxt_r.lv_vout  = r_ff.lv_vout;
            endcase
        end
        // zero length until a log exists
        nxt_r.len = log_present_in ? FLRB_BLOCK_LEN : FLRB_EMPTY_LEN;
        case (r_ff.state)
            FLRB_IDLE: begin
                if (fault_in) begin
                    nxt_r.state = FLRB_FINISH;
                end else if (fault_record_read_in && log_present_in) begin
                    nxt_r.pos   = FLRB_FIRST_BYTE;
                    nxt_r.state = FLRB_EMIT;
                end
            end
            FLRB_FINISH: begin
                // keep converting until the pass closes at step 25
                if (adc_valid_in && adc_step_in == FLRB_LAST_STEP) begin
                    // freeze the page here; readings after this edge only
                    // reach the live copies, never the record
                    nxt_r.vout     = nxt_r.lv_vout;
                    nxt_r.iout     = nxt_r.lv_iout;
                    nxt_r.ichan    = nxt_r.lv_ichan;
                    nxt_r.vin      = nxt_r.lv_vin;
                    nxt_r.iin      = nxt_r.lv_iin;
                    nxt_r.text     = nxt_r.lv_text;
                    nxt_r.tint     = nxt_r.lv_tint;
                    nxt_r.pk_ichan = peak_channel_input_current_in;
                    nxt_r.pk_vin   = peak_input_voltage_in;
                    nxt_r.pk_text  = peak_external_temperature_in;
                    nxt_r.vstat    = vout_status_in;
                    nxt_r.req      = 1'b1;
                    nxt_r.state    = FLRB_WAIT;
                end
            end
            FLRB_WAIT: begin
                // hold the store request until the write engine is done;
                // store_done_in is a one-cycle pulse and only counts here
                if (store_done_in) begin
                    nxt_r.req   = 1'b0;
                    nxt_r.state = FLRB_IDLE;
                end
            end
            FLRB_EMIT: begin
                // a stalled fifo holds pos; the byte is rebuilt from the frozen page
                emit_valid = 1'b1;
                if (fifo_ready) begin
                    nxt_r.pos = r_ff.pos + 8'd1;
                    if (r_ff.pos == FLRB_LAST_BYTE) begin
                        nxt_r.state = FLRB_IDLE;
                    end
                end
            end
            default: nxt_r.state = FLRB_IDLE;
        endcase
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // clock enable low freezes every field; the fifo obeys the same enable
    // so a stalled core never loses a half-moved byte
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r_ff <= '{state: FLRB_IDLE, pos: FLRB_POS_RST, vstat: FLRB_RSVD_BYTE, req: 1'b0,
                      len: FLRB_EMPTY_LEN, default: FLRB_WORD_RST};
        end else if (clk_en_in) begin
            r_ff <= nxt_r;
        end
    end

    // ****************************************************************
    // byte stream buffer
    // ****************************************************************
    // fifo decouples the serial host's pace from the builder; eight bytes
    // of slack cover a host that stalls briefly between block bytes
    flrb_fifo #(
        .W     (FLRB_DATA_W),
        .DEPTH (FLRB_FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in   (core_clk_in),
        .rst_b_in      (rst_b_in),
        .clk_en_in     (clk_en_in),
        .in_valid_in   (emit_valid),
        .in_ready_out  (fifo_ready),
        .in_data_in    (emit_byte),
        .out_valid_out (byte_valid_out),
        .out_ready_in  (byte_ready_in),
        .out_data_out  (byte_data_out)
    );

    // ****************************************************************
    // port outputs
    // ****************************************************************
    // request and length come straight from registers
    assign store_req_out = r_ff.req;
    assign block_len_out = r_ff.len;
    assign busy_out      = (r_ff.state != FLRB_IDLE);
endmodule

// File: design/flrb_pkg.sv
// Purpose: shared constants for the fault record builder
// Assumes: 40 MHz core clock, byte stream of the record section 13..39
// Notes:   all offsets are record byte positions
package flrb_pkg;
    localparam int          FLRB_DATA_W      = 8;
    localparam int          FLRB_FIFO_DEPTH  = 8;
    localparam logic [7:0]  FLRB_FIRST_BYTE  = 8'h0D;   // 13
    localparam logic [7:0]  FLRB_LAST_BYTE   = 8'h27;   // 39
    localparam logic [7:0]  FLRB_BLOCK_LEN   = 8'h93;   // 147
    localparam logic [7:0]  FLRB_EMPTY_LEN   = 8'h00;
    localparam logic [4:0]  FLRB_LAST_STEP   = 5'h19;   // 25
    localparam logic [7:0]  FLRB_RSVD_BYTE   = 8'h00;
    localparam logic [15:0] FLRB_WORD_RST    = 16'h0000;
    localparam logic [7:0]  FLRB_POS_RST     = 8'h00;

    // step codes of the conversion sequencer carrying each reading
    localparam logic [4:0]  FLRB_STEP_VOUT   = 5'h01;
    localparam logic [4:0]  FLRB_STEP_IOUT   = 5'h03;
    localparam logic [4:0]  FLRB_STEP_ICHAN  = 5'h05;
    localparam logic [4:0]  FLRB_STEP_VIN    = 5'h07;
    localparam logic [4:0]  FLRB_STEP_IIN    = 5'h09;
    localparam logic [4:0]  FLRB_STEP_TEXT   = 5'h0B;
    localparam logic [4:0]  FLRB_STEP_TINT   = 5'h0D;

    typedef enum logic [1:0] {
        FLRB_IDLE  = 2'b00,
        FLRB_FINISH = 2'b01,
        FLRB_EMIT  = 2'b10,
        FLRB_WAIT  = 2'b11
    } flrb_state_t;
endpackage

// File: design/flrb_fifo.sv
// Purpose: small valid/ready fifo for the record byte stream
// Assumes: single clock, asynchronous active-low reset
// Notes:   depth must be a power of two
module flrb_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         core_clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         clk_en_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    input  wire logic [W-1:0] in_data_in,
    output logic              out_valid_out,
    input  wire logic         out_ready_in,
    output logic [W-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_ff [DEPTH];
    logic [AW:0]  wr_ff;
    logic [AW:0]  rd_ff;
    logic         push;
    logic         pop;

    // full when pointers differ only in the wrap bit
    assign in_ready_out  = !((wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
    assign out_valid_out = (wr_ff != rd_ff);
    assign out_data_out  = mem_ff[rd_ff[AW-1:0]];
    assign push = clk_en_in && in_valid_in && in_ready_out;
    assign pop  = clk_en_in && out_valid_out && out_ready_in;

    // storage has no reset; only pointers need one
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem_ff[wr_ff[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            if (push) wr_ff <= wr_ff + 1'b1;
            if (pop)  rd_ff <= rd_ff + 1'b1;
        end
    end
endmodule

// File: test/flrb_monitor.sv
// Purpose: port checks of the record builder
// Assumes: checks pause while the clock enable is low
// Notes:   bound from the bench top file
module flrb_monitor
    import flrb_pkg::*;
(
    input wire logic       core_clk_in,
    input wire logic       rst_b_in,
    input wire logic       clk_en_in,
    input wire logic       fault_in,
    input wire logic       adc_valid_in,
    input wire logic [4:0] adc_step_in,
    input wire logic       log_present_in,
    input wire logic       fault_record_read_in,
    input wire logic       store_done_in,
    input wire logic       store_req_out,
    input wire logic [7:0] block_len_out,
    input wire logic       byte_valid_out,
    input wire logic       busy_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in || !clk_en_in);
    logic pend_ff;
    // taken fault remembered until its store request shows
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) pend_ff <= 1'b0;
        else if (clk_en_in && fault_in && !busy_out) pend_ff <= 1'b1;
        else if (store_req_out) pend_ff <= 1'b0;
    end
    sequence pass_end_s; pend_ff && adc_valid_in && adc_step_in == FLRB_LAST_STEP; endsequence
    sequence take_read_s; fault_record_read_in && log_present_in && !busy_out; endsequence
    len_full_a: assert property (log_present_in |=> block_len_out == FLRB_BLOCK_LEN)
        else $error("block length not full");
    len_empty_a: assert property (!log_present_in |=> block_len_out == FLRB_EMPTY_LEN)
        else $error("block length not zero");
    read_start_a: assert property (take_read_s |=> busy_out ##1 byte_valid_out)
        else $error("first byte late");
    read_refuse_a: assert property (fault_record_read_in && !log_present_in && !busy_out |=> !busy_out)
        else $error("read without log taken");
    fault_take_a: assert property (fault_in && !busy_out |=> busy_out)
        else $error("fault not taken");
    store_pass_a: assert property (pass_end_s |=> store_req_out)
        else $error("no store after step 25");
    store_hold_a: assert property (store_req_out && !store_done_in |=> store_req_out)
        else $error("store request dropped");
    store_end_a: assert property (store_req_out && store_done_in |=> !store_req_out)
        else $error("store request stuck");
    store_cause_a: assert property ($rose(store_req_out) |-> $past(pend_ff && adc_valid_in && adc_step_in == 5'h19))
        else $error("store before pass end");
endmodule

// File: test/flrb_host.sv
// Purpose: serial host side draining the record bytes
// Assumes: one byte taken per edge with ready high
// Notes:   long hold-off at each read start so the fifo fills
module flrb_host (
    input  wire logic       core_clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       valid_in,
    input  wire logic [7:0] data_in,
    output logic            ready_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] q [$];
    logic [3:0] hold_ff = 4'h0;
    initial ready_out = 1'b0;
    // long stall first, random stalls after
    always @(posedge core_clk_in) begin
        if (valid_in && ready_out) q.push_back(data_in);
        if (q.size() != 0) hold_ff <= 4'h0;
        else if (valid_in && hold_ff != 4'hf) hold_ff <= hold_ff + 4'h1;
        ready_out <= rst_b_in && (hold_ff == 4'hf || (q.size() != 0 && $urandom_range(3) != 0));
    end
endmodule

// File: test/flrb_builder_tb.sv
// Purpose: random and corner runs of the record builder
// Assumes: clock enable high except one two-cycle low stretch per round; step codes from the package
// Notes:   expected bytes come from the readings the bench sent
module flrb_builder_tb;
    import flrb_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rst_b = 1'b0, fi = 1'b0, av = 1'b0, lp = 1'b0, rdp = 1'b0, sd = 1'b0;
    logic        ce = 1'b1;
    logic [4:0]  st = 5'h00;
    logic [15:0] ad = 16'h0000;
    logic [15:0] pk [3] = '{default: 16'h0000};
    logic [15:0] rd [32], keep [32];
    logic [15:0] epk [3];
    logic [7:0]  vst = 8'h00;
    logic        sr, bv, br, busy;
    logic [7:0]  len, bd;
    int          mismatches = 0, checked = 0;
    always #12.5 clk = ~clk;
    flrb_builder flrb_builder_i (.core_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(ce), .fault_in(fi),
        .adc_valid_in(av), .adc_step_in(st), .adc_data_in(ad), .peak_channel_input_current_in(pk[0]),
        .peak_input_voltage_in(pk[1]), .peak_external_temperature_in(pk[2]), .vout_status_in(vst),
        .log_present_in(lp), .fault_record_read_in(rdp), .store_done_in(sd), .store_req_out(sr),
        .block_len_out(len), .byte_valid_out(bv), .byte_ready_in(br), .byte_data_out(bd), .busy_out(busy));
    flrb_host flrb_host_i (.core_clk_in(clk), .rst_b_in(rst_b), .valid_in(bv), .data_in(bd), .ready_out(br));
    task automatic conclude();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // bounded wait on store request (0) or busy (1)
    task automatic wait_lvl(input int which, input logic lvl);
        for (int n = 0; (which ? busy : sr) !== lvl; n++) begin
            if (n == 40) begin
                mismatches++;
                conclude();
            end
            @(posedge clk);
            #1;
        end
    endtask
    // back-to-back readings for steps a..b; k gives a fixed byte-order pattern
    task automatic pass(input int a, input int b, input bit k);
        logic [15:0] d;
        for (int s = a; s <= b; s++) begin
            d = k ? 16'h8001 : 16'($urandom);
            rd[s] = d;
            @(posedge clk);
            av <= 1'b1;
            st <= 5'(s);
            ad <= d;
        end
        @(posedge clk);
        av <= 1'b0;
    endtask
    function automatic logic [7:0] exp_b(input int p);
        logic [15:0] w;
        case (p)
            13, 14: w = epk[0];
            15, 16: w = epk[1];
            17, 18: w = rd[FLRB_STEP_TEXT];
            21, 22: w = rd[FLRB_STEP_TINT];
            23, 24: w = epk[2];
            27, 28: w = rd[FLRB_STEP_VOUT];
            31, 32: w = rd[FLRB_STEP_IOUT];
            33, 34: w = rd[FLRB_STEP_ICHAN];
            35, 36: w = rd[FLRB_STEP_VIN];
            37, 38: w = rd[FLRB_STEP_IIN];
            39: w = {vst, 8'h00};
            default: w = 16'h0000;
        endcase
        return p[0] ? w[15:8] : w[7:0];
    endfunction
    // round 0 is the corner: fault just before the last step
    initial begin
        int m;
        logic [15:0] v;
        void'($urandom(32'h1aef_7aa5));
        repeat (8) @(posedge clk);
        chk(len, FLRB_EMPTY_LEN);
        rst_b <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            lp <= 1'b0;
            rdp <= 1'b1;
            foreach (pk[i]) begin
                v = r == 0 ? 16'hff00 : 16'($urandom);
                pk[i] <= v;
                epk[i] = v;
            end
            vst <= 8'($urandom);
            @(posedge clk);
            rdp <= 1'b0;
            repeat (2) @(posedge clk);
            chk(8'(busy), 8'h00);
            chk(len, FLRB_EMPTY_LEN);
            m = r == 0 ? 24 : $urandom_range(2, 23);
            pass(1, m, r == 0);
            @(posedge clk);
            fi <= 1'b1;
            @(posedge clk);
            fi <= 1'b0;
            pass(m + 1, 25, r == 0);
            wait_lvl(0, 1'b1);
            chk(8'(sr), 8'h01);
            repeat ($urandom_range(1, 4)) @(posedge clk);
            sd <= 1'b1;
            @(posedge clk);
            sd <= 1'b0;
            wait_lvl(1, 1'b0);
            // later readings and peaks must not reach the stored page
            keep = rd;
            foreach (pk[i]) pk[i] <= ~epk[i];
            pass(1, 25, 1'b0);
            rd = keep;
            // a fault while the clock enable is low is never taken
            ce <= 1'b0;
            fi <= 1'b1;
            repeat (2) @(posedge clk);
            ce <= 1'b1;
            fi <= 1'b0;
            @(posedge clk);
            #1 chk(8'(busy), 8'h00);
            @(posedge clk);
            lp <= 1'b1;
            rdp <= 1'b1;
            @(posedge clk);
            rdp <= 1'b0;
            for (int n = 0; flrb_host_i.q.size() < 27; n++) begin
                if (n == 500) begin
                    mismatches++;
                    conclude();
                end
                @(posedge clk);
            end
            for (int p = 13; p <= 39; p++) chk(flrb_host_i.q[p-13], exp_b(p));
            chk(len, FLRB_BLOCK_LEN);
            flrb_host_i.q.delete();
        end
        conclude();
    end
endmodule
bind flrb_builder flrb_monitor flrb_monitor_i (.*);
